// ===== hw/lwps_sram.sv
// Late-write pipelined static memory with write buffer and read bypass.
`timescale 1ns/1ps
`include "lwps_map.svh"
module lwps_sram (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Synchronous command pins.
  input wire lwps_pkg::lwps_cmd_t cmd_pins,
  // Data pins, split into input, output and output enable.
  input wire lwps_pkg::lwps_data_t data_pins_in,
  output logic [`LWPS_DATA_W-1:0] data_pins_out,
  output logic data_pins_oe,
  // Asynchronous controls.
  input wire logic output_enable_n,
  input wire logic sleep_select
);
  localparam int ZZE_CYC = `LWPS_ZZE_CYC;
  localparam int DEPTH = 1 << `LWPS_ADDR_W;

  lwps_pkg::lwps_state_t st_r;
  lwps_pkg::lwps_state_t st_nxt;
  lwps_pkg::lwps_data_t mem [DEPTH];
  lwps_pkg::lwps_data_t mem_rd;
  lwps_pkg::lwps_data_t rd_merged;
  logic rd_take;
  logic wr_take;
  logic commit;
  lwps_pkg::lwps_addr_t cm_addr;
  lwps_pkg::lwps_be_t cm_be_n;
  lwps_pkg::lwps_data_t cm_data;

  // Lay new data over old data on the lanes whose enable is low.
  function automatic lwps_pkg::lwps_data_t lane_merge(
    input lwps_pkg::lwps_data_t base,
    input lwps_pkg::lwps_data_t upd,
    input lwps_pkg::lwps_be_t be_n);
    lwps_pkg::lwps_data_t res;
    res = base;
    for (int i = 0; i < `LWPS_LANES; i++) begin
      if (!be_n[i]) begin
        res[i*`LWPS_LANE_W +: `LWPS_LANE_W] =
          upd[i*`LWPS_LANE_W +: `LWPS_LANE_W];
      end
    end
    return res;
  endfunction

  // Address compare, shared by bypass paths and checks.
  function automatic logic addr_hit(input lwps_pkg::lwps_addr_t a,
                                    input lwps_pkg::lwps_addr_t b);
    return a == b;
  endfunction

  // Commands decode only from clean pins; a sleeping part takes none.
  // Only one protocol exists, so no mode pins are decoded.
  assign rd_take = !st_r.slp_sync && !cmd_pins.select_n &&
                   cmd_pins.write_enable_n;
  assign wr_take = !st_r.slp_sync && !cmd_pins.select_n &&
                   !cmd_pins.write_enable_n;
  // The pending write drains only when a fresh write address shows up.
  assign commit = wr_take && (st_r.buf_valid || st_r.wp_pend);

  // Back-to-back writes leave no room to park the older data, so data
  // still on the pins goes straight to the array; otherwise a second
  // buffer entry would be needed. The buffer is always empty then.
  always_comb begin
    if (st_r.wp_pend) begin
      cm_addr = st_r.wp_addr;
      cm_be_n = st_r.wp_be_n;
      cm_data = data_pins_in;
    end else begin
      cm_addr = st_r.buf_addr;
      cm_be_n = st_r.buf_be_n;
      cm_data = st_r.buf_data;
    end
  end

  // Array read during the cycle after the address edge.
  assign mem_rd = mem[st_r.rd_addr];

  // Newest data wins: array, then buffer, then data arriving this cycle.
  always_comb begin
    rd_merged = mem_rd;
    if (st_r.buf_valid && addr_hit(st_r.buf_addr, st_r.rd_addr)) begin
      rd_merged = lane_merge(rd_merged, st_r.buf_data,
                             st_r.buf_be_n);
    end
    if (st_r.wp_pend && addr_hit(st_r.wp_addr, st_r.rd_addr)) begin
      rd_merged = lane_merge(rd_merged, data_pins_in,
                             st_r.wp_be_n);
    end
  end

  // Next-state logic for the whole front end.
  always_comb begin
    st_nxt = st_r;
    st_nxt.slp_meta = sleep_select;
    st_nxt.slp_sync = st_r.slp_meta;
    st_nxt.rd_pend = rd_take;
    if (rd_take) begin
      st_nxt.rd_addr = cmd_pins.address_pins;
    end
    st_nxt.wp_pend = wr_take;
    if (wr_take) begin
      st_nxt.wp_addr = cmd_pins.address_pins;
      st_nxt.wp_be_n = cmd_pins.byte_write_enable_n;
    end
    if (commit) begin
      st_nxt.buf_valid = 1'b0;
    end
    // Data follows its address by one cycle and parks in the buffer,
    // unless a new write address sends it straight to the array.
    if (st_r.wp_pend && !wr_take) begin
      st_nxt.buf_valid = 1'b1;
      st_nxt.buf_addr = st_r.wp_addr;
      st_nxt.buf_be_n = st_r.wp_be_n;
      st_nxt.buf_data = data_pins_in;
    end
    // Output register loads at the edge after the array access.
    if (st_r.rd_pend) begin
      st_nxt.dout = rd_merged;
    end
    // Reads drive the pins next cycle; writes and deselects float them.
    st_nxt.drive = st_r.rd_pend && !st_r.slp_sync;
  end

  // State register; the memory itself is never reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Commit keeps lanes that the original write left disabled.
  always_ff @(posedge clk) begin
    if (!rst && commit) begin
      mem[cm_addr] <= lane_merge(mem[cm_addr], cm_data,
                                 cm_be_n);
    end
  end

  // Output enable and sleep gate the pin drive without the clock, since
  // the host may hold the clock still around a sleep change.
  assign data_pins_out = st_r.dout;
  assign data_pins_oe = st_r.drive && !output_enable_n &&
                        !sleep_select;

  // Checks.
  property p_rd_lat;
    @(posedge clk) disable iff (rst) rd_take |=> ##1 st_r.drive;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read did not drive pins two edges later");

  property p_wr_float;
    @(posedge clk) disable iff (rst)
      (wr_take || cmd_pins.select_n) |=> ##1 !st_r.drive;
  endproperty
  a_wr_float: assert property (p_wr_float)
    else $error("write or deselect left pins driven");

  property p_oe_async;
    @(posedge clk) disable iff (rst) output_enable_n |-> !data_pins_oe;
  endproperty
  a_oe_async: assert property (p_oe_async)
    else $error("pins driven while output enable is high");

  property p_sleep_float;
    @(posedge clk) disable iff (rst)
      $rose(st_r.slp_sync) |-> ##[0:ZZE_CYC] !st_r.drive;
  endproperty
  a_sleep_float: assert property (p_sleep_float)
    else $error("sleep did not stop the output drive in time");

  property p_buf_load;
    @(posedge clk) disable iff (rst)
      (st_r.wp_pend && !wr_take) |=> st_r.buf_valid &&
        st_r.buf_addr == $past(st_r.wp_addr) &&
        st_r.buf_data == $past(data_pins_in);
  endproperty
  a_buf_load: assert property (p_buf_load)
    else $error("write data not parked in the buffer");

  property p_buf_hold;
    @(posedge clk) disable iff (rst)
      (st_r.buf_valid && !wr_take && !st_r.wp_pend) |=>
        st_r.buf_valid && $stable(st_r.buf_data) && $stable(st_r.buf_addr);
  endproperty
  a_buf_hold: assert property (p_buf_hold)
    else $error("buffer changed without a new write");

  property p_one_entry;
    @(posedge clk) disable iff (rst) st_r.wp_pend |-> !st_r.buf_valid;
  endproperty
  a_one_entry: assert property (p_one_entry)
    else $error("write buffer asked to hold two entries");

  property p_commit;
    @(posedge clk) disable iff (rst)
      commit |=> !st_r.buf_valid;
  endproperty
  a_commit: assert property (p_commit)
    else $error("buffer not drained on the next write address");

  property p_bypass;
    @(posedge clk) disable iff (rst)
      (st_r.rd_pend && st_r.buf_valid && st_r.buf_be_n == '0 &&
       addr_hit(st_r.buf_addr, st_r.rd_addr) &&
       !(st_r.wp_pend && addr_hit(st_r.wp_addr, st_r.rd_addr)))
      |=> st_r.dout == $past(st_r.buf_data);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("read hit did not return buffered data");

  property p_fresh;
    @(posedge clk) disable iff (rst)
      (wr_take && cmd_pins.byte_write_enable_n == '0) ##1
      (rd_take && cmd_pins.address_pins == $past(cmd_pins.address_pins))
      |=> ##1 st_r.dout == $past(data_pins_in, 2);
  endproperty
  a_fresh: assert property (p_fresh)
    else $error("read missed data arriving in the same cycle");

  property p_miss;
    @(posedge clk) disable iff (rst)
      (st_r.rd_pend && !(st_r.buf_valid &&
         addr_hit(st_r.buf_addr, st_r.rd_addr)) &&
       !(st_r.wp_pend && addr_hit(st_r.wp_addr, st_r.rd_addr)))
      |=> st_r.dout == $past(mem_rd);
  endproperty
  a_miss: assert property (p_miss)
    else $error("read miss did not return array contents");

  c_read: cover property (@(posedge clk) disable iff (rst)
    rd_take ##2 data_pins_oe);
  c_back2back_wr: cover property (@(posedge clk) disable iff (rst)
    wr_take ##1 wr_take ##1 wr_take);
  c_bypass: cover property (@(posedge clk) disable iff (rst)
    st_r.rd_pend && st_r.buf_valid && addr_hit(st_r.buf_addr, st_r.rd_addr));
  c_sleep: cover property (@(posedge clk) disable iff (rst)
    $rose(st_r.slp_sync));
endmodule

// ===== hw/lwps_map.svh
// Constants for the late-write pipelined static memory block.
// Overview of operation
// - Read address latched at a rising edge; array read before the next.
// - Read data lands in an output register, valid after the second edge.
// - A read after a write to the same address returns the newest data.
// - Buffered data reaches the array only at the next write address.
// - Pending write data and address wait in a one-entry write buffer.
// - A read of the buffered address gets buffer data on its enabled lanes and array data on the rest.
// - Raising sleep select floats the data outputs within 15.0 ns.
// - Output enable high floats the outputs within 2.0 ns, clock or not.
// - Select, write enables and address sampled only at rising edges.
// - Four active-low byte write enables, each gating one nine-bit lane.
// - Writes and deselects float outputs; reads drive them; all clocked.
// - Only the single-clock pipelined read protocol exists.
`ifndef LWPS_MAP_SVH
`define LWPS_MAP_SVH
`define LWPS_ADDR_W 21
`define LWPS_LANES 4
`define LWPS_LANE_W 9
`define LWPS_DATA_W (`LWPS_LANES * `LWPS_LANE_W)
`define LWPS_CLK_PS 4000
`define LWPS_T_ZZE_PS 15000
`define LWPS_T_ZZR_PS 20000
`define LWPS_ZZE_CYC (`LWPS_T_ZZE_PS / `LWPS_CLK_PS)
`define LWPS_ZZR_CYC ((`LWPS_T_ZZR_PS + `LWPS_CLK_PS - 1) / `LWPS_CLK_PS)
`endif

// ===== hw/lwps_pkg.sv
// Types shared by the late-write pipelined static memory block.
`include "lwps_map.svh"
package lwps_pkg;
  typedef logic [`LWPS_ADDR_W-1:0] lwps_addr_t;
  typedef logic [`LWPS_DATA_W-1:0] lwps_data_t;
  typedef logic [`LWPS_LANES-1:0] lwps_be_t;

  // Synchronous command pins, all sampled on the rising clock edge.
  typedef struct packed {
    logic select_n;
    logic write_enable_n;
    lwps_be_t byte_write_enable_n;
    lwps_addr_t address_pins;
  } lwps_cmd_t;

  // Whole register state of the memory front end.
  typedef struct packed {
    logic slp_meta;
    logic slp_sync;
    logic rd_pend;
    lwps_addr_t rd_addr;
    logic wp_pend;
    lwps_addr_t wp_addr;
    lwps_be_t wp_be_n;
    logic buf_valid;
    lwps_addr_t buf_addr;
    lwps_be_t buf_be_n;
    lwps_data_t buf_data;
    lwps_data_t dout;
    logic drive;
  } lwps_state_t;
endpackage

// ===== bench/lwps_host.sv
// Host-side model that hands write data over one cycle after the command.
`timescale 1ns/1ps
module lwps_host (
  // Clock.
  input wire logic clk,
  // Command on the pins and the data that goes with it.
  input wire lwps_pkg::lwps_cmd_t cmd_pins,
  input wire lwps_pkg::lwps_data_t wr_data,
  // Data lines toward the memory.
  output lwps_pkg::lwps_data_t data_pins_in
);
  initial data_pins_in = '0;
  // Outside a data cycle the lines toggle, so a late capture cannot pass.
  always @(posedge clk) begin
    if (!cmd_pins.select_n && !cmd_pins.write_enable_n) begin
      data_pins_in <= wr_data;
    end else begin
      data_pins_in <= ~data_pins_in;
    end
  end
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the late-write pipelined static memory.
`timescale 1ns/1ps
`include "lwps_map.svh"
module tb_top;
  logic clk = 1'b0;
  logic run = 1'b1;
  logic rst = 1'b1;
  logic output_enable_n = 1'b0;
  logic sleep_select = 1'b0;
  lwps_pkg::lwps_cmd_t cmd_pins = '1;
  lwps_pkg::lwps_data_t wr_data = '0;
  lwps_pkg::lwps_data_t data_pins_in;
  lwps_pkg::lwps_data_t nxt;
  lwps_pkg::lwps_data_t exp_rd;
  logic [`LWPS_DATA_W-1:0] data_pins_out;
  logic data_pins_oe;
  lwps_pkg::lwps_data_t mem [lwps_pkg::lwps_addr_t];
  lwps_pkg::lwps_data_t exp_q [$];
  lwps_pkg::lwps_addr_t addrs [8];
  logic [1:0] rd_pipe = 2'h0;
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  // The clock can be parked low while sleep select changes.
  always #2 clk = run ? ~clk : clk;

  lwps_sram u_dut (.clk(clk), .rst(rst), .cmd_pins(cmd_pins),
    .data_pins_in(data_pins_in), .data_pins_out(data_pins_out),
    .data_pins_oe(data_pins_oe), .output_enable_n(output_enable_n),
    .sleep_select(sleep_select));
  lwps_host u_host (.clk(clk), .cmd_pins(cmd_pins), .wr_data(wr_data),
    .data_pins_in(data_pins_in));

  task automatic check(input string what, input lwps_pkg::lwps_data_t exp,
                       input lwps_pkg::lwps_data_t got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One whole command per cycle; the expected read is the newest merge.
  task automatic op(input logic wr, input lwps_pkg::lwps_addr_t a,
                    input lwps_pkg::lwps_be_t be_n,
                    input lwps_pkg::lwps_data_t d);
    if (wr) begin
      nxt = mem.exists(a) ? mem[a] : '0;
      for (int i = 0; i < `LWPS_LANES; i++) begin
        if (!be_n[i]) nxt[i*`LWPS_LANE_W +: `LWPS_LANE_W] =
          d[i*`LWPS_LANE_W +: `LWPS_LANE_W];
      end
      mem[a] = nxt;
    end else begin
      exp_q.push_back(mem[a]);
    end
    cmd_pins <= '{1'b0, ~wr, be_n, a};
    wr_data <= d;
    @(posedge clk);
  endtask

  // Parks the clock low, since sleep select must not move under an edge.
  // Sleep is entered with a read on the pins, so the float is visible.
  task automatic sleep_to(input logic lvl);
    @(negedge clk);
    run = 1'b0;
    check("oe before sleep", 36'(lvl), 36'(data_pins_oe));
    sleep_select = lvl;
    #1 check("sleep float", '0, 36'(data_pins_oe));
    #2 run = 1'b1;
    repeat (`LWPS_ZZR_CYC) @(posedge clk);
  endtask

  // Watcher: a read taken at one edge is compared two edges later.
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      errors++;
      results();
    end
    if (rd_pipe[1]) begin
      exp_rd = exp_q.pop_front();
      if (!output_enable_n) begin
        check("read", exp_rd, data_pins_out);
      end
      check("read oe", 36'(!output_enable_n && !sleep_select),
            36'(data_pins_oe));
    end else if (!rst) begin
      check("idle oe", '0, 36'(data_pins_oe));
    end
    rd_pipe <= {rd_pipe[0], !rst && !cmd_pins.select_n &&
                cmd_pins.write_enable_n};
  end

  initial begin
    void'($urandom(61288));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (addrs[i]) addrs[i] = 21'($urandom);
    foreach (addrs[i]) op(1'b1, addrs[i], 4'h0, 36'({$urandom, $urandom}));
    foreach (addrs[i]) op(1'b0, addrs[i], 4'hF, '0);
    $display("Test fill done");
    for (int b = 0; b < 16; b++) begin
      op(1'b1, addrs[0], 4'(b), 36'({$urandom, $urandom}));
      op(1'b0, addrs[0], 4'hF, '0);
      op(1'b0, addrs[1], 4'hF, '0);
    end
    $display("Test lane enables done");
    repeat (300) op(1'($urandom), addrs[$urandom_range(7)], 4'($urandom),
                    36'({$urandom, $urandom}));
    $display("Test random mix done");
    op(1'b0, addrs[2], 4'hF, '0);
    op(1'b0, addrs[3], 4'hF, '0);
    cmd_pins <= '1;
    output_enable_n <= 1'b1;
    #1 check("async float", '0, 36'(data_pins_oe));
    @(posedge clk);
    output_enable_n <= 1'b0;
    repeat (3) @(posedge clk);
    $display("Test output enable done");
    op(1'b0, addrs[4], 4'hF, '0);
    cmd_pins <= '1;
    @(posedge clk);
    sleep_to(1'b1);
    sleep_to(1'b0);
    foreach (addrs[i]) op(1'b0, addrs[i], 4'hF, '0);
    cmd_pins <= '1;
    repeat (4) @(posedge clk);
    $display("Test sleep done");
    results();
  end
endmodule
